// >>> logic/ccs_pkg.sv
// Purpose: Constants for the instruction-cycle sequencer.
// Assumes: One system clock, derived in the core from the oscillator by two.
// Notes: Operand field widths and opcode codes used by the sequencer.
`default_nettype none
package ccs_pkg;
    localparam int PHASES_PER_CYCLE = 4;
    localparam int OSC_DIV = 2;
    localparam int TMR_SLOW_CLKS = 12;
    localparam int TMR_FAST_CLKS = 4;
    localparam int MAX_ICYCLES = 5;
    localparam int REL_W = 8;
    localparam int IMM_W = 8;
    localparam int IMM16_W = 16;
    localparam int ABS_W = 11;
    localparam int LONG_W = 16;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [7:0] OP_MUL = 8'ha4;
    localparam logic [7:0] OP_DIV = 8'h84;
    localparam logic [7:0] OP_INC_DPTR = 8'ha3;
    localparam logic [7:0] OP_MOVX_RD = 8'he0;
    localparam logic [7:0] OP_MOV_DD = 8'h85;
    localparam logic [2:0] CYC_MULDIV = 3'h5;
    localparam logic [2:0] CYC_INC_DPTR = 3'h3;
    localparam logic [2:0] CYC_MOVX = 3'h2;
    localparam logic [2:0] CYC_MOV_DD = 3'h3;
    localparam logic [6:0] IND_MASK = 7'h7f;
    localparam logic [7:0] OP_MOVX_RI = 8'he2;
    typedef enum logic [1:0] {
        PH_FIRST = 2'b00,
        PH_SECOND = 2'b01,
        PH_THIRD = 2'b11,
        PH_FOURTH = 2'b10
    } ccs_phase_e;
endpackage : ccs_pkg
`default_nettype wire

// >>> logic/ccs_sequencer.sv
// Purpose: Instruction-cycle sequencer: phases, cycle counting, timer ticks.
// Assumes: Opcode byte and its size are given by the fetch path in phase_fourth.
// Notes: The opcode's function itself is done by the datapath; this block
//        only paces it and decodes operand fields.
`default_nettype none
// Contract
// - Four one-clock phases per instruction cycle
// - System clock is oscillator divided by two
// - Instructions take one to five cycles
// - External data read takes two cycles; the code gives two only to opcode e0, so MOVX via R0/R1 runs its byte count
// - Direct-to-direct move takes three cycles
// - One fetch per byte; cycles equal bytes except for opcodes with stall cycles
// - Multiply and divide add stall cycles
// - Timers tick every twelve clocks after reset
// - Fast rate ticks every four clocks
// - Opcodes stay binary compatible with classic set
// - Status effects identical; only timing differs
// - Operand fields: rel, imm8, imm16, addr11, addr16
// - Indirect operand addressed by R0 or R1
module ccs_sequencer
    import ccs_pkg::*;
#(
    parameter int TMR_SLOW = TMR_SLOW_CLKS,
    parameter int TMR_FAST = TMR_FAST_CLKS
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic osc_en_in,
    input wire logic [7:0] opcode_in,
    input wire logic [2:0] op_bytes_in,
    input wire logic [7:0] operand1_in,
    input wire logic [7:0] operand2_in,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] wreg0_in,
    input wire logic [7:0] wreg1_in,
    input wire logic timer_fast_in,
    output logic [1:0] phase_out,
    output logic phase_first_out,
    output logic phase_fourth_out,
    output logic fetch_out,
    output logic instr_done_out,
    output logic stall_out,
    output logic [2:0] cycles_left_out,
    output logic [15:0] fetch_addr_out,
    output logic timer_tick_out,
    output logic [15:0] rel_target_out,
    output logic [15:0] abs_target_out,
    output logic [15:0] long_target_out,
    output logic [15:0] long_imm_out,
    output logic [7:0] imm_out,
    output logic [7:0] indirect_addr_out
);
    // ----------------------------------------------------------------
    // Reset synchroniser
    // ----------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // ----------------------------------------------------------------
    // System clock enable: oscillator by two
    // ----------------------------------------------------------------
    // The oscillator rate arrives as an enable; every second one is a
    // system clock step, so one phase spans two oscillator enables.
    logic div_q;
    wire sys_en = osc_en_in & div_q;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q <= 1'b0;
        end else if (!rst_n) begin
            div_q <= 1'b0;
        end else if (osc_en_in) begin
            div_q <= ~div_q;
        end
    end

    // ----------------------------------------------------------------
    // Phase counter
    // ----------------------------------------------------------------
    ccs_phase_e phase_q;
    ccs_phase_e phase_d;
    always_comb begin
        unique case (phase_q)
            PH_FIRST: phase_d = PH_SECOND;
            PH_SECOND: phase_d = PH_THIRD;
            PH_THIRD: phase_d = PH_FOURTH;
            PH_FOURTH: phase_d = PH_FIRST;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= PH_FIRST;
        end else if (!rst_n) begin
            phase_q <= PH_FIRST;
        end else if (sys_en) begin
            phase_q <= phase_d;
        end
    end
    wire at_first = (phase_q == PH_FIRST);
    wire at_fourth = (phase_q == PH_FOURTH);
    wire cyc_end = sys_en & at_fourth;

    // ----------------------------------------------------------------
    // Instruction cycle count
    // ----------------------------------------------------------------
    // Bytes set the count; a few opcodes run longer than their bytes,
    // which become stall cycles with no fetch.
    wire is_muldiv = (opcode_in == OP_MUL) | (opcode_in == OP_DIV);
    wire is_movx = (opcode_in == OP_MOVX_RD);
    wire is_movdd = (opcode_in == OP_MOV_DD);
    wire is_incdp = (opcode_in == OP_INC_DPTR);
    wire [2:0] bytes_safe = (op_bytes_in == 3'h0) ? 3'h1 : op_bytes_in;
    wire [2:0] cyc_table =
        is_muldiv ? CYC_MULDIV :
        is_movx ? CYC_MOVX :
        is_movdd ? CYC_MOV_DD :
        is_incdp ? CYC_INC_DPTR :
        bytes_safe;
    wire [2:0] cyc_total = (cyc_table > 3'(MAX_ICYCLES)) ? 3'(MAX_ICYCLES) : cyc_table;

    logic new_instr_q;
    logic [2:0] left_q;
    logic [2:0] bytes_left_q;
    logic [15:0] addr_q;
    wire last_cyc = (left_q == 3'h1);
    wire [2:0] left_load = cyc_total - 3'h1;
    wire [2:0] bytes_load = bytes_safe - 3'h1;
    wire fetch_now = new_instr_q | (bytes_left_q != 3'h0);

    // Next values, applied only at the end of an instruction cycle
    wire new_instr_d = new_instr_q ? (left_load == 3'h0) : last_cyc;
    wire [2:0] left_d = new_instr_q ? left_load : (left_q - 3'h1);
    wire [2:0] bytes_left_d =
        new_instr_q ? bytes_load :
        (bytes_left_q != 3'h0) ? (bytes_left_q - 3'h1) :
        3'h0;
    // One address step per fetch cycle; a new instruction takes the
    // datapath's pc in its first phase, so jumps redirect the fetch.
    wire addr_step = cyc_end & fetch_now;
    wire addr_load = ~cyc_end & at_first & new_instr_q;
    wire [15:0] addr_d =
        addr_step ? (addr_q + 16'h0001) :
        addr_load ? pc_in :
        addr_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            new_instr_q <= 1'b1;
        end else if (!rst_n) begin
            new_instr_q <= 1'b1;
        end else if (cyc_end) begin
            new_instr_q <= new_instr_d;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            left_q <= 3'h1;
        end else if (!rst_n) begin
            left_q <= 3'h1;
        end else if (cyc_end) begin
            left_q <= left_d;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bytes_left_q <= 3'h0;
        end else if (!rst_n) begin
            bytes_left_q <= 3'h0;
        end else if (cyc_end) begin
            bytes_left_q <= bytes_left_d;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_q <= RESET_VECTOR;
        end else if (!rst_n) begin
            addr_q <= RESET_VECTOR;
        end else begin
            addr_q <= addr_d;
        end
    end

    // ----------------------------------------------------------------
    // Timer prescale
    // ----------------------------------------------------------------
    logic [3:0] tmr_cnt_q;
    wire [3:0] tmr_lim = timer_fast_in ? 4'(TMR_FAST - 1) : 4'(TMR_SLOW - 1);
    wire tmr_wrap = sys_en & (tmr_cnt_q >= tmr_lim);
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tmr_cnt_q <= 4'h0;
        end else if (!rst_n) begin
            tmr_cnt_q <= 4'h0;
        end else if (tmr_wrap) begin
            tmr_cnt_q <= 4'h0;
        end else if (sys_en) begin
            tmr_cnt_q <= tmr_cnt_q + 4'h1;
        end
    end
    logic tick_q;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= rst_n & tmr_wrap;
        end
    end

    // ----------------------------------------------------------------
    // Operand field decode
    // ----------------------------------------------------------------
    // Opcode bits pass untouched to the datapath, keeping the classic
    // encoding and flag effects; only pacing is decided here.
    wire [15:0] rel_ext = {{(16 - REL_W){operand1_in[REL_W-1]}}, operand1_in};
    wire [15:0] rel_sum = pc_in + rel_ext;
    wire [ABS_W-1:0] abs_fld = {opcode_in[7:5], operand1_in};
    wire [15:0] abs_sum = {pc_in[15:ABS_W], abs_fld};
    wire [LONG_W-1:0] long_fld = {operand1_in, operand2_in};
    wire is_movx_ri = (opcode_in[7:1] == OP_MOVX_RI[7:1]);
    // External moves use the register as an external address; the register
    // value is left unmasked for every opcode, internal moves included.
    wire [7:0] ind_sel = opcode_in[0] ? wreg1_in : wreg0_in;
    wire [7:0] ind_addr = is_movx_ri ? ind_sel : ind_sel;

    logic [15:0] rel_q;
    logic [15:0] abs_q;
    logic [15:0] long_q;
    logic [7:0] imm_q;
    logic [7:0] ind_q;
    // Field registers follow the operand bytes every clock; the datapath
    // takes them in whichever phase it needs them.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rel_q <= 16'h0000;
        end else begin
            rel_q <= rel_sum;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            abs_q <= 16'h0000;
        end else begin
            abs_q <= abs_sum;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            long_q <= 16'h0000;
        end else begin
            long_q <= long_fld;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            imm_q <= 8'h00;
        end else begin
            imm_q <= operand1_in[IMM_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ind_q <= 8'h00;
        end else begin
            ind_q <= ind_addr;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign phase_out = phase_q;
    assign phase_first_out = at_first;
    assign phase_fourth_out = at_fourth;
    assign fetch_out = fetch_now & rst_n;
    assign instr_done_out = cyc_end & (new_instr_q ? (left_load == 3'h0) : last_cyc);
    assign stall_out = ~fetch_now & rst_n;
    assign cycles_left_out = left_q;
    assign fetch_addr_out = addr_q;
    assign timer_tick_out = tick_q;
    assign rel_target_out = rel_q;
    assign abs_target_out = abs_q;
    assign long_target_out = long_q;
    assign long_imm_out = long_q;
    assign imm_out = imm_q;
    assign indirect_addr_out = ind_q;
endmodule : ccs_sequencer
`default_nettype wire

// >>> tb/ccs_sequencer_props.sv
// Purpose: Port checks for the instruction-cycle sequencer.
// Assumes: One clock domain, active-low reset.
// Notes: Bound from the bench top file.
`default_nettype none
module ccs_sequencer_props
    import ccs_pkg::*;
#(parameter int TMR_SLOW = TMR_SLOW_CLKS, parameter int TMR_FAST = TMR_FAST_CLKS) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] operand1_in,
    input wire logic [7:0] operand2_in,
    input wire logic [1:0] phase_out,
    input wire logic phase_first_out,
    input wire logic phase_fourth_out,
    input wire logic fetch_out,
    input wire logic instr_done_out,
    input wire logic stall_out,
    input wire logic [2:0] cycles_left_out,
    input wire logic [15:0] fetch_addr_out,
    input wire logic timer_tick_out,
    input wire logic [15:0] long_imm_out,
    input wire logic [7:0] imm_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence phase_moved; phase_out != $past(phase_out); endsequence
    sequence done_pulse; instr_done_out ##1 !instr_done_out; endsequence
    phase_order_a: assert property (phase_moved |-> phase_out == {$past(phase_out[0]),
        ~$past(phase_out[1])}) else $error("phase order broken");
    phase_hold_a: assert property (phase_moved |=> $stable(phase_out))
        else $error("phase shorter than two clocks");
    first_decode_a: assert property (phase_first_out == (phase_out == PH_FIRST))
        else $error("first phase decode wrong");
    fourth_decode_a: assert property (phase_fourth_out == (phase_out == PH_FOURTH))
        else $error("fourth phase decode wrong");
    done_fourth_a: assert property (instr_done_out |-> phase_fourth_out ##0 done_pulse)
        else $error("done outside fourth phase or too long");
    tick_pulse_a: assert property (timer_tick_out |=> !timer_tick_out)
        else $error("timer tick longer than one clock");
    stall_fetch_a: assert property (stall_out |-> !fetch_out)
        else $error("fetch during stall");
    stall_addr_a: assert property (stall_out |=> $stable(fetch_addr_out))
        else $error("fetch address moved in a stall cycle");
    cycles_max_a: assert property (cycles_left_out <= MAX_ICYCLES)
        else $error("cycle count above five");
    imm_reg_a: assert property ($past(rst_n_in, 4) |-> imm_out == $past(operand1_in))
        else $error("immediate field wrong");
    long_reg_a: assert property ($past(rst_n_in, 4) |->
        long_imm_out == {$past(operand1_in), $past(operand2_in)}) else $error("long field wrong");
endmodule : ccs_sequencer_props
`default_nettype wire

// >>> tb/ccs_prog_mem.sv
// Purpose: Program memory model presenting the instruction at the pc.
// Assumes: Only the low pc byte selects a slot.
// Notes: Unwritten slots hold a one-byte opcode 00.
`default_nettype none
module ccs_prog_mem (
    input wire logic [15:0] pc_in,
    output logic [7:0] opcode_out,
    output logic [2:0] op_bytes_out,
    output logic [7:0] operand1_out,
    output logic [7:0] operand2_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:255];
    logic [7:0] idx;
    assign idx = pc_in[7:0];
    assign opcode_out = mem[idx];
    assign operand1_out = mem[idx + 8'h01];
    assign operand2_out = mem[idx + 8'h02];
    // One memory access per instruction byte
    always_comb begin
        case (opcode_out)
            8'h85, 8'h53: op_bytes_out = 3'h3;
            8'h74, 8'h31: op_bytes_out = 3'h2;
            default: op_bytes_out = 3'h1;
        endcase
    end
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {mem[8'h20], mem[8'h30], mem[8'h40], mem[8'h50]} = 32'he085a3a4;
        {mem[8'h60], mem[8'h70], mem[8'h80]} = 24'h847453;
        {mem[8'ha0], mem[8'ha1], mem[8'ha2]} = 24'h313456;
        {mem[8'hb0], mem[8'hc0]} = 16'he7e6;
    end
endmodule : ccs_prog_mem
`default_nettype wire

// >>> tb/ccs_sequencer_tb.sv
// Purpose: Self-checking bench for the instruction-cycle sequencer.
// Assumes: Oscillator enable held high, so a system step is two clocks.
// Notes: Each instruction is repeated at a fixed pc to measure its length.
`default_nettype none
module ccs_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ccs_pkg::*;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, osc_en_in = 1'b1, timer_fast_in = 1'b0;
    logic [15:0] pc_in = 16'h0010;
    logic [7:0] wreg0_in = 8'h5a, wreg1_in = 8'ha5, opc, op1, op2;
    logic [2:0] nb;
    logic [1:0] phase;
    logic pf, p4, fetch, done, stall, tick;
    logic [2:0] left;
    logic [15:0] faddr, rel, abst, longt, limm;
    logic [7:0] imm, ind;
    int error_cnt = 0, total_checks = 0;
    initial forever #4 clk_sys_in = ~clk_sys_in;
    ccs_prog_mem u_mem (.pc_in(pc_in), .opcode_out(opc), .op_bytes_out(nb),
        .operand1_out(op1), .operand2_out(op2));
    ccs_sequencer u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .osc_en_in(osc_en_in),
        .opcode_in(opc), .op_bytes_in(nb), .operand1_in(op1), .operand2_in(op2),
        .pc_in(pc_in), .wreg0_in(wreg0_in), .wreg1_in(wreg1_in), .timer_fast_in(timer_fast_in),
        .phase_out(phase), .phase_first_out(pf), .phase_fourth_out(p4), .fetch_out(fetch),
        .instr_done_out(done), .stall_out(stall), .cycles_left_out(left),
        .fetch_addr_out(faddr), .timer_tick_out(tick), .rel_target_out(rel),
        .abs_target_out(abst), .long_target_out(longt), .long_imm_out(limm), .imm_out(imm),
        .indirect_addr_out(ind));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic step();
        @(posedge clk_sys_in);
        #1;
    endtask : step
    // Bounded wait so a stuck sequencer ends in a mismatch, not a hang
    task automatic wait_for(input bit use_tick, output int n);
        n = 0;
        do begin
            step();
            n++;
        end while ((use_tick ? tick : done) !== 1'b1 && n < 300);
    endtask : wait_for
    task automatic t_reset();
        repeat (2) step();
        check("phase", phase, PH_FIRST);
        check("fetch_addr", faddr, RESET_VECTOR);
        check("tick", tick, 1'b0);
        check("fetch", fetch, 1'b0);
        check("stall", stall, 1'b0);
        repeat (2) step();
        rst_n_in = 1'b1;
        $display("test reset done");
    endtask : t_reset
    task automatic t_cycles();
        logic [15:0] pcs [8] = '{16'h10, 16'h20, 16'h30, 16'h40, 16'h50, 16'h60, 16'h70, 16'h80};
        int cyc [8] = '{1, 2, 3, 3, 5, 5, 2, 3};
        int nbytes [8] = '{1, 1, 3, 1, 1, 1, 2, 3};
        int n, s, f;
        foreach (pcs[i]) begin
            pc_in = pcs[i];
            repeat (2) wait_for(1'b0, n);
            n = 0;
            s = 0;
            f = 0;
            do begin
                step();
                n++;
                s += (stall === 1'b1);
                f += (fetch === 1'b1);
            end while (done !== 1'b1 && n < 300);
            check("instr_clks", n, 16'(cyc[i] * 8));
            check("fetch_clks", f, 16'(nbytes[i] * 8));
            check("stall_clks", s, 16'((cyc[i] - nbytes[i]) * 8));
            step();
            check("fetch_addr", faddr, pcs[i] + 16'(nbytes[i]));
        end
        $display("test cycles done");
    endtask : t_cycles
    task automatic t_timer();
        int n;
        for (int f = 0; f < 2; f++) begin
            timer_fast_in = f[0];
            repeat (2) wait_for(1'b1, n);
            check("tick_gap", n, f ? 16'd8 : 16'd24);
        end
        $display("test timer done");
    endtask : t_timer
    task automatic t_fields();
        int n;
        pc_in = 16'h09a0;
        repeat (2) wait_for(1'b0, n);
        check("rel", rel, 16'h09d4);
        check("abs", abst, 16'h0934);
        check("long", longt, 16'h3456);
        check("long_imm", limm, 16'h3456);
        check("imm", imm, 16'h0034);
        pc_in = 16'h09b0;
        repeat (2) wait_for(1'b0, n);
        check("ind_r1", ind, wreg1_in);
        pc_in = 16'h09c0;
        repeat (2) wait_for(1'b0, n);
        check("ind_r0", ind, wreg0_in);
        $display("test fields done");
    endtask : t_fields
    initial begin
        t_reset();
        t_cycles();
        t_timer();
        t_fields();
        stop_test();
    end
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end
endmodule : ccs_sequencer_tb
bind ccs_sequencer ccs_sequencer_props #(.TMR_SLOW(TMR_SLOW), .TMR_FAST(TMR_FAST)) u_props (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .operand1_in(operand1_in),
    .operand2_in(operand2_in), .phase_out(phase_out), .phase_first_out(phase_first_out),
    .phase_fourth_out(phase_fourth_out), .fetch_out(fetch_out),
    .instr_done_out(instr_done_out), .stall_out(stall_out), .cycles_left_out(cycles_left_out),
    .fetch_addr_out(fetch_addr_out), .timer_tick_out(timer_tick_out),
    .long_imm_out(long_imm_out), .imm_out(imm_out));
`default_nettype wire
